//--- logic/mdc_pkg.sv
// Purpose: shared types and constants for the multi-channel transfer engine
// Assumes: one 125 MHz clock, asynchronous active-low reset
// Notes: channel settings arrive as plain ports, one packed struct per channel
package mdc_pkg;

    // ------------------------------------------------------------
    // field widths and reset values
    // ------------------------------------------------------------
    localparam int MADDR_W = 24;
    localparam int PADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int COUNT_W = 14;
    localparam int SEL_W = 8;
    localparam logic [COUNT_W-1:0] IDX_RESET = 14'h0000;

    // ------------------------------------------------------------
    // addressing modes and operating mode bits
    // ------------------------------------------------------------
    localparam logic [1:0] AMODE_POSTINC = 2'h0;
    localparam logic [1:0] AMODE_NOINC = 2'h1;
    localparam logic [1:0] AMODE_PERIPH = 2'h2;
    localparam int MODE_ONESHOT_BIT = 0;
    localparam int MODE_PINGPONG_BIT = 1;

    // ------------------------------------------------------------
    // request source codes
    // ------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_EXTERNAL_INTERRUPT_ZERO = 8'h00;
    localparam logic [SEL_W-1:0] SEL_SECOND_INPUT_CAPTURE = 8'h05;
    localparam logic [SEL_W-1:0] SEL_TIMER_TWO = 8'h07;
    localparam logic [SEL_W-1:0] SEL_FIRST_UART_RECEIVER = 8'h0b;
    localparam logic [SEL_W-1:0] SEL_FIRST_CONVERTER = 8'h0d;
    localparam logic [SEL_W-1:0] SEL_FIRST_CAN_RX = 8'h22;
    localparam logic [SEL_W-1:0] SEL_CODEC_INTERFACE = 8'h3c;

    // ------------------------------------------------------------
    // peripheral data register addresses
    // ------------------------------------------------------------
    localparam logic [PADDR_W-1:0] PAD_FIRST_UART_RECEIVE_BUFFER = 16'h0226;
    localparam logic [PADDR_W-1:0] PAD_SECOND_CAPTURE_BUFFER = 16'h014c;
    localparam logic [PADDR_W-1:0] PAD_FIRST_CONVERTER_RESULT = 16'h0300;
    localparam logic [PADDR_W-1:0] PAD_FIRST_CAN_RX = 16'h0440;
    localparam logic [PADDR_W-1:0] PAD_CODEC_RX = 16'h0290;
    localparam logic [PADDR_W-1:0] PAD_CODEC_TX = 16'h0298;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } mdc_state_e;

    typedef struct packed {
        logic enable;
        logic byte_size;
        logic dir_mem_to_periph;
        logic half_irq;
        logic [1:0] amode;
        logic [1:0] mode;
        logic [SEL_W-1:0] request_source_select;
        logic [MADDR_W-1:0] start_a;
        logic [MADDR_W-1:0] start_b;
        logic [PADDR_W-1:0] channel_peripheral_address_reg;
        logic [COUNT_W-1:0] channel_transfer_count;
    } mdc_chan_cfg_s;

    typedef struct packed {
        logic req;
        logic we;
        logic byte_sel;
        logic [MADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mdc_bus_req_s;

endpackage : mdc_pkg

//--- logic/mdc_dma_core.sv
// Purpose: multi-channel engine moving elements between peripherals and memory
// Assumes: read data is valid in the cycle a read request is accepted
// Notes: the buffer ram port never stalls; the shared ram port waits for its grant
//
// Contract
// - up to fifteen independent peripheral channels
// - buffer ram has own bus, never stalls
// - shared ram access waits on arbiter grant
// - transfers continue while cpu is halted
// - each channel moves one direction only
// - lowest channel number wins, others stay pending
// - interrupt cpu when block is moved
// - interrupt at half or full block
// - byte or word elements per channel
// - post-increment mode advances address per element
// - non-increment mode reuses one address
// - peripheral-indirect uses peripheral-supplied address
// - start by manual trigger or request
// - one-shot stops, continuous restarts the block
// - ping-pong swaps start address per block
// - request source chosen from any interrupt
// - code 00 external interrupt, 07 timer
// - code 0b uart receiver at 0226
// - code 0d converter reads first result
// - code 22 selects can receive ready
// - code 3c codec reads rx, writes tx
// - code 05 second capture at 014c
// - manual trigger cleared only by hardware
// - mode field: pingpong bit1, oneshot bit0
// - fourteen-bit transfer count per channel
`timescale 1ns/1ps
module mdc_dma_core #(
    parameter int NCH = 15,
    parameter logic [23:0] DPR_BASE = 24'h004000,
    parameter logic [23:0] DPR_SIZE = 24'h001000
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire mdc_pkg::mdc_chan_cfg_s [NCH-1:0] cfg_i,
    input wire logic [NCH-1:0] force_set_i,
    input wire logic [255:0] req_src_i,
    input wire logic [NCH-1:0][23:0] periph_mem_addr_i,
    output mdc_pkg::mdc_bus_req_s dpr_o,
    input wire logic [15:0] dpr_rdata_i,
    output mdc_pkg::mdc_bus_req_s srm_o,
    input wire logic srm_gnt_i,
    input wire logic [15:0] srm_rdata_i,
    output mdc_pkg::mdc_bus_req_s per_o,
    input wire logic [15:0] per_rdata_i,
    output logic [NCH-1:0] block_irq_o,
    output logic [NCH-1:0] force_pending_o,
    output logic [NCH-1:0] ppsel_o,
    output logic busy_o
);

    // one index bit minimum keeps a single-channel build legal
    localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

    // ------------------------------------------------------------
    // default peripheral address per request source
    // ------------------------------------------------------------
    function automatic logic [15:0] default_pad(input logic [7:0] sel, input logic to_periph);
        logic [15:0] r;
        r = 16'h0000;
        unique case (sel)
            mdc_pkg::SEL_FIRST_UART_RECEIVER: r = mdc_pkg::PAD_FIRST_UART_RECEIVE_BUFFER;
            mdc_pkg::SEL_SECOND_INPUT_CAPTURE: r = mdc_pkg::PAD_SECOND_CAPTURE_BUFFER;
            mdc_pkg::SEL_FIRST_CONVERTER: r = mdc_pkg::PAD_FIRST_CONVERTER_RESULT;
            mdc_pkg::SEL_FIRST_CAN_RX: r = mdc_pkg::PAD_FIRST_CAN_RX;
            mdc_pkg::SEL_CODEC_INTERFACE: r = to_periph ? mdc_pkg::PAD_CODEC_TX : mdc_pkg::PAD_CODEC_RX;
            default: r = 16'h0000;
        endcase
        return r;
    endfunction : default_pad

    // ------------------------------------------------------------
    // channel state
    // ------------------------------------------------------------
    // element index within the current block
    logic [NCH-1:0][13:0] idx;
    logic [NCH-1:0] pend;
    logic [NCH-1:0] force_q;
    logic [NCH-1:0] pp;
    logic [NCH-1:0] stopped;
    logic [NCH-1:0] src_hit;
    logic [NCH-1:0] ready;
    logic [NCH-1:0] fin;

    // engine state
    mdc_pkg::mdc_state_e state;
    mdc_pkg::mdc_state_e next_state;

    logic [CW-1:0] cur;
    logic [CW-1:0] next_cur;

    logic by_force;
    logic next_by_force;

    logic dir_q;
    logic next_dir_q;

    logic in_dpr;
    logic next_in_dpr;

    logic [23:0] maddr;
    logic [23:0] next_maddr;

    logic [15:0] paddr;
    logic [15:0] next_paddr;

    logic byte_q;
    logic next_byte_q;

    mdc_pkg::mdc_bus_req_s next_dpr;
    mdc_pkg::mdc_bus_req_s next_srm;
    mdc_pkg::mdc_bus_req_s next_per;

    // ------------------------------------------------------------
    // request decode and arbitration
    // ------------------------------------------------------------
    logic any_ready;
    logic [CW-1:0] pick;
    always_comb begin
        any_ready = 1'b0;
        pick = '0;
        for (int c = NCH - 1; c >= 0; c--) begin
            if (ready[c]) begin
                any_ready = 1'b1;
                pick = CW'(c);
            end
        end
    end

    // address selection for the picked channel
    mdc_pkg::mdc_chan_cfg_s pcfg;
    logic [23:0] pbase;
    logic [23:0] pstep_off;
    logic [23:0] pmaddr;
    logic [15:0] ppaddr;
    logic pin_dpr;
    assign pcfg = cfg_i[pick];
    assign pbase = pp[pick] ? pcfg.start_b : pcfg.start_a;
    assign pstep_off = pcfg.byte_size ? {10'h000, idx[pick]} : {9'h000, idx[pick], 1'b0};
    assign pmaddr = (pcfg.amode == mdc_pkg::AMODE_PERIPH) ? periph_mem_addr_i[pick] :
                    (pcfg.amode == mdc_pkg::AMODE_NOINC) ? pbase :
                    pbase + pstep_off;
    assign ppaddr = (pcfg.channel_peripheral_address_reg != 16'h0000) ? pcfg.channel_peripheral_address_reg :
                    default_pad(pcfg.request_source_select, pcfg.dir_mem_to_periph);
    // buffer ram window decides which memory port carries the access
    assign pin_dpr = (pmaddr >= DPR_BASE) && (pmaddr < DPR_BASE + DPR_SIZE);

    // completion conditions
    logic rd_ok;
    logic wr_ok;
    logic [15:0] rd_data;
    // only the shared ram port can stall; the buffer ram and peripherals always answer
    assign rd_ok = (dir_q && !in_dpr) ? srm_gnt_i : 1'b1;
    assign wr_ok = (!dir_q && !in_dpr) ? srm_gnt_i : 1'b1;
    assign rd_data = !dir_q ? per_rdata_i : (in_dpr ? dpr_rdata_i : srm_rdata_i);

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    // no cpu halt input exists: the engine never waits on the cpu
    always_comb begin
        next_state = state;
        next_cur = cur;
        next_by_force = by_force;
        next_dir_q = dir_q;
        next_in_dpr = in_dpr;
        next_maddr = maddr;
        next_paddr = paddr;
        next_byte_q = byte_q;
        next_dpr = dpr_o;
        next_srm = srm_o;
        next_per = per_o;
        unique case (state)
            // arbitration only in idle, so an element is never split
            mdc_pkg::ST_IDLE: begin
                if (any_ready) begin
                    next_state = mdc_pkg::ST_READ;
                    next_cur = pick;
                    next_by_force = force_q[pick];
                    next_dir_q = pcfg.dir_mem_to_periph;
                    next_in_dpr = pin_dpr;
                    next_maddr = pmaddr;
                    next_paddr = ppaddr;
                    next_byte_q = pcfg.byte_size;
                    if (pcfg.dir_mem_to_periph) begin
                        next_dpr = '{req: pin_dpr,
                            we: 1'b0,
                            byte_sel: pcfg.byte_size,
                            addr: pmaddr,
                            wdata: 16'h0000};
                        next_srm = '{req: !pin_dpr,
                            we: 1'b0,
                            byte_sel: pcfg.byte_size,
                            addr: pmaddr,
                            wdata: 16'h0000};
                    end else begin
                        next_per = '{req: 1'b1, we: 1'b0, byte_sel: pcfg.byte_size, addr: {8'h00, ppaddr},
                                     wdata: 16'h0000};
                    end
                end
            end

            mdc_pkg::ST_READ: begin
                if (rd_ok) begin
                    next_state = mdc_pkg::ST_WRITE;
                    next_dpr.req = 1'b0;
                    next_srm.req = 1'b0;
                    next_per.req = 1'b0;
                    // read data is only valid in the completion cycle
                    if (dir_q) begin
                        next_per = '{req: 1'b1,
                            we: 1'b1,
                            byte_sel: byte_q,
                            addr: {8'h00, paddr},
                            wdata: rd_data};
                    end else begin
                        next_dpr = '{req: in_dpr,
                            we: 1'b1,
                            byte_sel: byte_q,
                            addr: maddr,
                            wdata: rd_data};
                        next_srm = '{req: !in_dpr,
                            we: 1'b1,
                            byte_sel: byte_q,
                            addr: maddr,
                            wdata: rd_data};
                    end
                end
            end

            mdc_pkg::ST_WRITE: begin
                if (wr_ok) begin
                    next_state = mdc_pkg::ST_IDLE;
                    next_dpr.req = 1'b0;
                    next_srm.req = 1'b0;
                    next_per.req = 1'b0;
                end
            end

            default: next_state = mdc_pkg::ST_IDLE;
        endcase
    end

    // bus words registered so no port can glitch
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= mdc_pkg::ST_IDLE;
            cur <= '0;
            by_force <= 1'b0;
            dir_q <= 1'b0;
            in_dpr <= 1'b0;
            maddr <= '0;
            paddr <= '0;
            byte_q <= 1'b0;
            dpr_o <= '0;
            srm_o <= '0;
            per_o <= '0;
            busy_o <= 1'b0;
        end else begin
            state <= next_state;
            cur <= next_cur;
            by_force <= next_by_force;
            dir_q <= next_dir_q;
            in_dpr <= next_in_dpr;
            maddr <= next_maddr;
            paddr <= next_paddr;
            byte_q <= next_byte_q;
            dpr_o <= next_dpr;
            srm_o <= next_srm;
            per_o <= next_per;
            busy_o <= (next_state != mdc_pkg::ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // per-channel bookkeeping
    // ------------------------------------------------------------
    // an element ends when its write is accepted
    logic elem_done;
    assign elem_done = (state == mdc_pkg::ST_WRITE) && wr_ok;

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic en;
        logic last;
        logic halfpt;
        logic oneshot;
        logic pingpong;
        logic next_pend;
        logic next_force;
        logic next_stop;
        logic [13:0] next_idx;
        logic next_pp;
        logic next_irq;

        assign en = cfg_i[c].enable;
        assign oneshot = cfg_i[c].mode[mdc_pkg::MODE_ONESHOT_BIT];
        assign pingpong = cfg_i[c].mode[mdc_pkg::MODE_PINGPONG_BIT];
        // selector 00 and 07 reach external interrupt zero and timer two through this index
        assign src_hit[c] = en && req_src_i[cfg_i[c].request_source_select];
        assign ready[c] = en && !stopped[c] && (pend[c] || force_q[c]);
        assign fin[c] = elem_done && (cur == CW'(c));
        assign last = (idx[c] == cfg_i[c].channel_transfer_count);
        assign halfpt = (idx[c] == (cfg_i[c].channel_transfer_count >> 1));
        assign next_irq = fin[c] && (cfg_i[c].half_irq ? halfpt : last);

        // set wins over the service clear so a request in the completion cycle survives
        assign next_pend = en && (src_hit[c] || (pend[c] && !(fin[c] && !by_force)));
        // no software clear path exists; only completion or disable drops it
        assign next_force = en && (force_set_i[c] || (force_q[c] && !(fin[c] && by_force)));

        assign next_idx = !en ? mdc_pkg::IDX_RESET :
                          fin[c] ? (last ? mdc_pkg::IDX_RESET : idx[c] + 14'h0001) : idx[c];
        assign next_pp = !en ? 1'b0 : (fin[c] && last && pingpong) ? !pp[c] : pp[c];
        // ping-pong one-shot stops only after both buffers were filled once
        assign next_stop = en && (stopped[c] || (fin[c] && last && oneshot && (!pingpong || pp[c])));

        // disable clears index, buffer select and stop together
        always_ff @(posedge mclk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                idx[c] <= mdc_pkg::IDX_RESET;
                pend[c] <= 1'b0;
                force_q[c] <= 1'b0;
                pp[c] <= 1'b0;
                stopped[c] <= 1'b0;
                block_irq_o[c] <= 1'b0;
            end else begin
                idx[c] <= next_idx;
                pend[c] <= next_pend;
                force_q[c] <= next_force;
                pp[c] <= next_pp;
                stopped[c] <= next_stop;
                block_irq_o[c] <= next_irq;
            end
        end
    end

    // status ports mirror state flops directly
    assign force_pending_o = force_q;
    assign ppsel_o = pp;

endmodule : mdc_dma_core

//--- verification/mdc_mem_model.sv
// Purpose: memories and peripherals on the far side of the transfer engine
// Assumes: read data valid in the cycle a read request is accepted
// Notes: shared ram grants every other cycle while slow_i is high
`timescale 1ns/1ps
module mdc_mem_model (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic slow_i,
    input wire mdc_pkg::mdc_bus_req_s dpr_i,
    input wire mdc_pkg::mdc_bus_req_s srm_i,
    input wire mdc_pkg::mdc_bus_req_s per_i,
    output logic [15:0] dpr_rdata_o,
    output logic srm_gnt_o,
    output logic [15:0] srm_rdata_o,
    output logic [15:0] per_rdata_o
);
    // ------
    // data lines
    // ------
    logic [15:0] noise;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            noise <= 16'h0000;
        end else begin
            noise <= noise + 16'h3b6d;
        end
    end
    // idle lines churn so a late sample shows up
    assign dpr_rdata_o = (dpr_i.req && !dpr_i.we) ? (dpr_i.addr[15:0] ^ 16'h1111) : noise;
    assign srm_gnt_o = srm_i.req && (!slow_i || noise[0]);
    assign srm_rdata_o = (srm_gnt_o && !srm_i.we) ? (srm_i.addr[15:0] ^ 16'h2222) : ~noise;
    assign per_rdata_o = (per_i.req && !per_i.we) ? (per_i.addr[15:0] ^ 16'ha5a5) : noise;
endmodule : mdc_mem_model

//--- verification/mdc_dma_core_assertions.sv
// Purpose: port checks for the transfer engine
// Assumes: one clock, reset active low
// Notes: bound to the engine below
`timescale 1ns/1ps
module mdc_dma_core_checker #(
    parameter int NCH = 15
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire mdc_pkg::mdc_chan_cfg_s [NCH-1:0] cfg_i,
    input wire logic [NCH-1:0] force_set_i,
    input wire logic [255:0] req_src_i,
    input wire mdc_pkg::mdc_bus_req_s dpr_o,
    input wire logic [15:0] dpr_rdata_i,
    input wire mdc_pkg::mdc_bus_req_s srm_o,
    input wire logic srm_gnt_i,
    input wire mdc_pkg::mdc_bus_req_s per_o,
    input wire logic [NCH-1:0] block_irq_o,
    input wire logic [NCH-1:0] force_pending_o,
    input wire logic [NCH-1:0] ppsel_o,
    input wire logic busy_o
);
    // ------
    // checks
    // ------
    logic [NCH-1:0] en;
    logic [NCH-1:0] hit;
    logic [NCH-1:0] fs;
    // stopped one-shot channels wait, so only continuous ones must start
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            en[c] = cfg_i[c].enable;
            hit[c] = en[c] && !cfg_i[c].mode[0] && req_src_i[cfg_i[c].request_source_select];
        end
    end
    assign fs = force_set_i & en;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    a_request_served: assert property (!busy_o && |hit |-> ##[1:3] busy_o)
        else $error("request on enabled channel not started");
    a_busy_reads: assert property ($rose(busy_o) |-> dpr_o.req || srm_o.req || per_o.req)
        else $error("engine busy without a read");
    a_force_seen: assert property (|fs |=> (force_pending_o & $past(fs)) == $past(fs))
        else $error("manual trigger not pending");
    a_force_dropped: assert property (1'b1 |=> (force_pending_o & ~$past(en)) == '0)
        else $error("trigger pending on disabled channel");
    a_pingpong_reset: assert property (1'b1 |=> (ppsel_o & ~$past(en)) == '0)
        else $error("buffer select kept on disabled channel");
    a_one_port: assert property ($onehot0({dpr_o.req, srm_o.req, per_o.req}))
        else $error("two ports requested at once");
    a_irq_after_move: assert property (|block_irq_o |-> $onehot(block_irq_o) && $past(busy_o))
        else $error("block interrupt without a move");
    a_dpr_one_cycle: assert property (dpr_o.req |=> !dpr_o.req)
        else $error("buffer ram request stalled");
    a_srm_wait: assert property (srm_o.req && !srm_gnt_i |=> srm_o.req && $stable(srm_o))
        else $error("shared ram request dropped before grant");
    a_data_moved: assert property (dpr_o.req && !dpr_o.we ##1 per_o.req |-> per_o.we
        && per_o.wdata == $past(dpr_rdata_i))
        else $error("written data differs from read data");
    c_irq: cover property (|block_irq_o);
    c_stall: cover property (srm_o.req && !srm_gnt_i);
    c_force: cover property (|force_pending_o);
endmodule : mdc_dma_core_checker
bind mdc_dma_core mdc_dma_core_checker #(.NCH(NCH)) u_mdc_dma_core_checker (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .cfg_i(cfg_i), .force_set_i(force_set_i), .req_src_i(req_src_i),
    .dpr_o(dpr_o), .dpr_rdata_i(dpr_rdata_i), .srm_o(srm_o), .srm_gnt_i(srm_gnt_i), .per_o(per_o),
    .block_irq_o(block_irq_o), .force_pending_o(force_pending_o), .ppsel_o(ppsel_o), .busy_o(busy_o));

//--- verification/mdc_dma_core_tb_top.sv
// Purpose: self-checking bench for the transfer engine
// Assumes: 125 MHz clock, reset low for two cycles
// Notes: plain moves run from a table, awkward cases follow
`timescale 1ns/1ps
module mdc_dma_core_tb_top;
    // ------
    // bench
    // ------
    typedef struct packed {
        logic [7:0] sel;
        logic dir;
        logic [1:0] amode;
        logic [15:0] pad;
        logic [23:0] start;
        logic [39:0] wr;
    } mdc_row_s;
    logic mclk;
    logic resetn;
    logic slow;
    mdc_pkg::mdc_chan_cfg_s [14:0] cfg;
    logic [14:0] force_set;
    logic [255:0] req_src;
    logic [14:0][23:0] pma;
    mdc_pkg::mdc_bus_req_s dpr, srm, per;
    logic [15:0] dpr_rd, srm_rd, per_rd;
    logic gnt, busy;
    logic [14:0] irq, fpend, ppsel;
    logic [39:0] wq[$];
    int fail_count = 0, n_checks = 0, irq_n = 0, irq_at = 0, byte_n = 0;
    mdc_row_s rows[8];
    mdc_dma_core u_mdc_dma_core (.mclk_i(mclk), .resetn_i(resetn), .cfg_i(cfg), .force_set_i(force_set),
        .req_src_i(req_src), .periph_mem_addr_i(pma), .dpr_o(dpr), .dpr_rdata_i(dpr_rd), .srm_o(srm),
        .srm_gnt_i(gnt), .srm_rdata_i(srm_rd), .per_o(per), .per_rdata_i(per_rd), .block_irq_o(irq),
        .force_pending_o(fpend), .ppsel_o(ppsel), .busy_o(busy));
    mdc_mem_model u_mdc_mem_model (.mclk_i(mclk), .resetn_i(resetn), .slow_i(slow), .dpr_i(dpr),
        .srm_i(srm), .per_i(per), .dpr_rdata_o(dpr_rd), .srm_gnt_o(gnt), .srm_rdata_o(srm_rd),
        .per_rdata_o(per_rd));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (resetn && dpr.req && dpr.we) wq.push_back({dpr.addr, dpr.wdata});
        if (resetn && dpr.req && dpr.we && dpr.byte_sel) byte_n++;
        if (resetn && per.req && per.we) wq.push_back({per.addr, per.wdata});
        if (resetn && srm.req && srm.we && gnt) wq.push_back({srm.addr, srm.wdata});
        if (resetn && |irq) begin
            irq_n++;
            irq_at = wq.size();
        end
    end
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic settle;
        int q = 0;
        for (int i = 0; i < 300 && q < 4; i++) begin
            tick(1);
            q = busy ? 0 : q + 1;
        end
    endtask : settle
    task automatic fire(input logic [7:0] sel);
        req_src[sel] = 1'b1;
        tick(1);
        req_src[sel] = 1'b0;
        settle();
    endtask : fire
    // one idle cycle with all channels off clears stop and buffer state
    task automatic clear_all;
        cfg = '0;
        tick(1);
        wq.delete();
        irq_n = 0;
        irq_at = 0;
        byte_n = 0;
    endtask : clear_all
    task automatic setup(input int c, input logic [7:0] sel, input logic [15:0] pad, input logic [23:0] a,
        input logic [23:0] b, input logic [1:0] mode);
        cfg[c].enable = 1'b1;
        cfg[c].request_source_select = sel;
        cfg[c].channel_peripheral_address_reg = pad;
        cfg[c].start_a = a;
        cfg[c].start_b = b;
        cfg[c].mode = mode;
    endtask : setup
    task automatic complete_run;
        $display("checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end
    initial begin
        resetn = 1'b0;
        slow = 1'b1;
        cfg = '0;
        force_set = '0;
        req_src = '0;
        pma = '0;
        pma[0] = 24'h004200;
        rows[0] = '{8'h0b, 1'b0, 2'h0, 16'h0000, 24'h004000, 40'h004000a783};
        rows[1] = '{8'h05, 1'b0, 2'h0, 16'h0000, 24'h004000, 40'h004000a4e9};
        rows[2] = '{8'h0d, 1'b0, 2'h0, 16'h0000, 24'h004000, 40'h004000a6a5};
        rows[3] = '{8'h22, 1'b0, 2'h0, 16'h0000, 24'h008000, 40'h008000a1e5};
        rows[4] = '{8'h3c, 1'b0, 2'h0, 16'h0000, 24'h004000, 40'h004000a735};
        rows[5] = '{8'h3c, 1'b1, 2'h0, 16'h0000, 24'h004010, 40'h0002985101};
        rows[6] = '{8'h00, 1'b1, 2'h0, 16'h0a00, 24'h008000, 40'h000a00a222};
        rows[7] = '{8'h07, 1'b0, 2'h2, 16'h0a02, 24'h004000, 40'h004200afa7};
        tick(2);
        check(40'({fpend, ppsel}), 40'h0);
        check(40'({busy, irq}), 40'h0);
        resetn = 1'b1;
        foreach (rows[i]) begin
            clear_all();
            setup(0, rows[i].sel, rows[i].pad, rows[i].start, 24'h000000, 2'h0);
            cfg[0].dir_mem_to_periph = rows[i].dir;
            cfg[0].amode = rows[i].amode;
            fire(rows[i].sel);
            check(40'(wq.size()), 40'h1);
            check(wq[0], rows[i].wr);
            check(40'(irq_n), 40'h1);
            $display("table row %0d done", i);
        end
        for (int k = 0; k < 4; k++) begin
            clear_all();
            setup(3, 8'h0d, 16'h0000, 24'h004100, 24'h000000, 2'h0);
            cfg[3].channel_transfer_count = 14'h0003;
            cfg[3].byte_size = (k == 1);
            cfg[3].amode = (k == 2) ? mdc_pkg::AMODE_NOINC : mdc_pkg::AMODE_POSTINC;
            cfg[3].half_irq = (k == 3);
            repeat (4) fire(8'h0d);
            for (int e = 0; e < 4; e++) begin
                check(40'(wq[e][39:16]), 40'(24'h004100 + e * ((k == 2) ? 0 : (k == 1) ? 1 : 2)));
            end
            check(40'(irq_at), (k == 3) ? 40'h2 : 40'h4);
            check(40'(byte_n), (k == 1) ? 40'h4 : 40'h0);
            check(40'(irq_n), 40'h1);
            $display("address step %0d done", k);
        end
        clear_all();
        setup(1, 8'h00, 16'h0b02, 24'h004030, 24'h000000, 2'h0);
        setup(14, 8'h07, 16'h0b00, 24'h004020, 24'h000000, 2'h0);
        req_src[0] = 1'b1;
        req_src[7] = 1'b1;
        tick(1);
        req_src = '0;
        settle();
        check(40'(wq[0][39:16]), 40'h004030);
        check(40'(wq[1][39:16]), 40'h004020);
        $display("priority done");
        for (int m = 0; m < 3; m++) begin
            clear_all();
            setup(4, 8'h07, 16'h0b00, 24'h004040, 24'h004050, (m == 0) ? 2'h2 : (m == 1) ? 2'h1 : 2'h3);
            repeat (3) fire(8'h07);
            check(40'(wq.size()), (m == 0) ? 40'h3 : (m == 1) ? 40'h1 : 40'h2);
            check(40'(wq[0][39:16]), 40'h004040);
            if (m != 1) check(40'(wq[1][39:16]), 40'h004050);
            if (m == 0) check(40'(ppsel[4]), 40'h1);
            $display("mode %0d done", m);
        end
        clear_all();
        setup(5, 8'hff, 16'h0b04, 24'h004060, 24'h000000, 2'h0);
        cfg[5].enable = 1'b0;
        force_set[5] = 1'b1;
        tick(1);
        force_set = '0;
        fire(8'hff);
        check(40'({fpend[5], wq.size()}), 40'h0);
        cfg[5].enable = 1'b1;
        force_set[5] = 1'b1;
        tick(1);
        force_set = '0;
        check(40'(fpend[5]), 40'h1);
        settle();
        check(40'(fpend[5]), 40'h0);
        check(wq[0], 40'h004060aea1);
        $display("manual trigger done");
        complete_run();
    end
endmodule : mdc_dma_core_tb_top
